// ---- tmr_pkg.sv ----
// Constants and types shared by the timer compare, flag and prescaler block
package tmr_pkg;

   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_CMP_A = 8'h00;
   localparam logic [7:0] OFS_CMP_B = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_GCTRL = 8'h10;
   localparam logic [7:0] OFS_TCTRL = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;

   // Bit positions in the mask, flag, general control and timer control registers
   localparam int MASK_CMPB_BIT = 3;
   localparam int MASK_CMPA_BIT = 2;
   localparam int MASK_OVF_BIT = 1;
   localparam int FLAG_CMPA_BIT = 4;
   localparam int FLAG_CMPB_BIT = 3;
   localparam int FLAG_OVF_BIT = 1;
   localparam int GCTRL_SYNC_BIT = 7;
   localparam int GCTRL_PSR_BIT = 0;
   localparam int TCTRL_CS_LSB = 0;
   localparam int TCTRL_WGM_LSB = 3;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Clock select field codes
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_SYS = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // Wave mode field codes
   localparam logic [2:0] WGM_NORMAL = 3'h0;
   localparam logic [2:0] WGM_PC_MAX = 3'h1;
   localparam logic [2:0] WGM_CTC = 3'h2;
   localparam logic [2:0] WGM_FAST_MAX = 3'h3;
   localparam logic [2:0] WGM_PC_TOPA = 3'h5;
   localparam logic [2:0] WGM_FAST_TOPA = 3'h7;

   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;

   // Prescaler taps: a tap fires when the low bits are all ones
   localparam int PRESC_W = 10;
   localparam logic [9:0] TAP_DIV8 = 10'h007;
   localparam logic [9:0] TAP_DIV64 = 10'h03F;
   localparam logic [9:0] TAP_DIV256 = 10'h0FF;
   localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic cmpA;
      logic cmpB;
      logic ovf;
   } tmr_evt_t;

endpackage

// ---- tmr_ext_edge.sv ----
// Two-stage synchroniser and edge detector for the external count pin
`timescale 1ns/10ps
`default_nettype none
module tmr_ext_edge (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic extCountPin,
   output logic riseEdge,
   output logic fallEdge
);
   logic syncFirst;
   logic syncSecond;
   logic pinLast;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         syncFirst <= 1'b0;
         syncSecond <= 1'b0;
         pinLast <= 1'b0;
      end else begin
         syncFirst <= extCountPin;
         syncSecond <= syncFirst;
         pinLast <= syncSecond;
      end
   end

   assign riseEdge = syncSecond && !pinLast;
   assign fallEdge = !syncSecond && pinLast;
endmodule
`default_nettype wire

// ---- tmr_timer0_cmp.sv ----
// Compare, interrupt flag and prescaler logic of the 8-bit timer with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tmr_timer0_cmp (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] counterValue,
   input wire logic globalIrqEn,
   input wire tmr_pkg::tmr_evt_t vectorAck,
   input wire logic extCountPin,
   output logic countPulse,
   output var tmr_pkg::tmr_evt_t eventPulse,
   output var tmr_pkg::tmr_evt_t irqReq,
   output logic [2:0] clockSelect,
   output logic [2:0] waveMode
);
   logic [7:0] awAddrQ;
   logic [7:0] wDataQ;
   logic wLaneQ;
   logic wrEn;
   logic [7:0] compareA;
   logic [7:0] compareB;
   tmr_pkg::tmr_evt_t irqEn;
   tmr_pkg::tmr_evt_t flags;
   tmr_pkg::tmr_evt_t flagClr;
   logic syncMode;
   logic prescReset;
   logic [tmr_pkg::PRESC_W-1:0] prescaler;
   logic countPulseD;
   logic extRise;
   logic extFall;
   logic next_countPulse;
   logic ovfPoint;
   logic [7:0] regRead;

   function automatic logic isMapped(input logic [7:0] addr);
      return addr == tmr_pkg::OFS_CMP_A || addr == tmr_pkg::OFS_CMP_B
         || addr == tmr_pkg::OFS_MASK || addr == tmr_pkg::OFS_FLAGS
         || addr == tmr_pkg::OFS_GCTRL || addr == tmr_pkg::OFS_TCTRL
         || addr == tmr_pkg::OFS_STATUS;
   endfunction

   function automatic logic wrHit(input logic [7:0] ofs);
      return wrEn && wLaneQ && awAddrQ == ofs;
   endfunction

   function automatic logic tapHit(input logic [tmr_pkg::PRESC_W-1:0] cnt,
                                   input logic [tmr_pkg::PRESC_W-1:0] tap);
      return (cnt & tap) == tap;
   endfunction

   // Write channel: address and data taken in either order
   assign wrEn = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tmr_pkg::RESP_OKAY;
         awAddrQ <= tmr_pkg::REG_RESET;
         wDataQ <= tmr_pkg::REG_RESET;
         wLaneQ <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awAddrQ <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wDataQ <= s_axi_wdata[7:0];
            wLaneQ <= s_axi_wstrb[0];
         end
         if (wrEn) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(awAddrQ) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Plain read/write registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         compareA <= tmr_pkg::REG_RESET;
         compareB <= tmr_pkg::REG_RESET;
         irqEn <= '0;
         clockSelect <= tmr_pkg::CS_STOP;
         waveMode <= tmr_pkg::WGM_NORMAL;
      end else begin
         if (wrHit(tmr_pkg::OFS_CMP_A)) begin
            compareA <= wDataQ;
         end
         if (wrHit(tmr_pkg::OFS_CMP_B)) begin
            compareB <= wDataQ;
         end
         if (wrHit(tmr_pkg::OFS_MASK)) begin
            irqEn.cmpA <= wDataQ[tmr_pkg::MASK_CMPA_BIT];
            irqEn.cmpB <= wDataQ[tmr_pkg::MASK_CMPB_BIT];
            irqEn.ovf <= wDataQ[tmr_pkg::MASK_OVF_BIT];
         end
         if (wrHit(tmr_pkg::OFS_TCTRL)) begin
            clockSelect <= wDataQ[tmr_pkg::TCTRL_CS_LSB +: 3];
            waveMode <= wDataQ[tmr_pkg::TCTRL_WGM_LSB +: 3];
         end
      end
   end

   // General control: sync mode and prescaler reset
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         syncMode <= 1'b0;
         prescReset <= 1'b0;
      end else if (wrHit(tmr_pkg::OFS_GCTRL)) begin
         // written reset value kept under sync mode
         syncMode <= wDataQ[tmr_pkg::GCTRL_SYNC_BIT];
         prescReset <= wDataQ[tmr_pkg::GCTRL_PSR_BIT];
      end else if (!syncMode) begin
         prescReset <= 1'b0;
      end
   end

   // free-running prescaler, only the reset bit stops it
   always_ff @(posedge clk_sys) begin
      if (!rst_n || prescReset) begin
         prescaler <= '0;
      end else begin
         prescaler <= prescaler + 1'b1;
      end
   end

   tmr_ext_edge u_ext_edge (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .extCountPin(extCountPin),
      .riseEdge(extRise),
      .fallEdge(extFall)
   );

   // count source select, pin edges bypass prescaler
   always_comb begin
      next_countPulse = 1'b0;
      unique case (clockSelect)
         tmr_pkg::CS_STOP: next_countPulse = 1'b0;
         tmr_pkg::CS_SYS: next_countPulse = 1'b1;
         tmr_pkg::CS_DIV8: next_countPulse = tapHit(prescaler, tmr_pkg::TAP_DIV8);
         tmr_pkg::CS_DIV64: next_countPulse = tapHit(prescaler, tmr_pkg::TAP_DIV64);
         tmr_pkg::CS_DIV256: next_countPulse = tapHit(prescaler, tmr_pkg::TAP_DIV256);
         tmr_pkg::CS_DIV1024: next_countPulse = tapHit(prescaler, tmr_pkg::TAP_DIV1024);
         // one pulse per selected pin edge
         tmr_pkg::CS_EXT_FALL: next_countPulse = extFall;
         tmr_pkg::CS_EXT_RISE: next_countPulse = extRise;
      endcase
      // Held prescaler reset halts the timer
      if (prescReset) begin
         next_countPulse = 1'b0;
      end
   end

   // pulse register closes the pin-to-count path
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         countPulse <= 1'b0;
         countPulseD <= 1'b0;
      end else begin
         countPulse <= next_countPulse;
         countPulseD <= countPulse;
      end
   end

   always_comb begin
      unique case (waveMode)
         tmr_pkg::WGM_NORMAL, tmr_pkg::WGM_CTC, tmr_pkg::WGM_FAST_MAX:
            ovfPoint = counterValue == tmr_pkg::CNT_MAX;
         tmr_pkg::WGM_PC_MAX, tmr_pkg::WGM_PC_TOPA:
            ovfPoint = counterValue == tmr_pkg::CNT_BOTTOM;
         tmr_pkg::WGM_FAST_TOPA:
            ovfPoint = counterValue == compareA;
         default:
            ovfPoint = 1'b0;
      endcase
   end

   // events on the updated counter value
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         eventPulse <= '0;
      end else begin
         eventPulse.cmpA <= countPulseD && counterValue == compareA;
         eventPulse.cmpB <= countPulseD && counterValue == compareB;
         eventPulse.ovf <= countPulseD && ovfPoint;
      end
   end

   // vector or written one clears a flag
   always_comb begin
      flagClr = vectorAck;
      if (wrHit(tmr_pkg::OFS_FLAGS)) begin
         flagClr.cmpA = flagClr.cmpA | wDataQ[tmr_pkg::FLAG_CMPA_BIT];
         flagClr.cmpB = flagClr.cmpB | wDataQ[tmr_pkg::FLAG_CMPB_BIT];
         flagClr.ovf = flagClr.ovf | wDataQ[tmr_pkg::FLAG_OVF_BIT];
      end
   end

   // set wins over clear, zero writes keep flags
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~flagClr) | eventPulse;
      end
   end

   // request is flag AND enable AND global
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irqReq <= '0;
      end else begin
         irqReq <= flags & irqEn & {3{globalIrqEn}};
      end
   end

   always_comb begin
      regRead = '0;
      unique case (s_axi_araddr)
         tmr_pkg::OFS_CMP_A: regRead = compareA;
         tmr_pkg::OFS_CMP_B: regRead = compareB;
         tmr_pkg::OFS_MASK: begin
            regRead[tmr_pkg::MASK_CMPA_BIT] = irqEn.cmpA;
            regRead[tmr_pkg::MASK_CMPB_BIT] = irqEn.cmpB;
            regRead[tmr_pkg::MASK_OVF_BIT] = irqEn.ovf;
         end
         tmr_pkg::OFS_FLAGS: begin
            regRead[tmr_pkg::FLAG_CMPA_BIT] = flags.cmpA;
            regRead[tmr_pkg::FLAG_CMPB_BIT] = flags.cmpB;
            regRead[tmr_pkg::FLAG_OVF_BIT] = flags.ovf;
         end
         tmr_pkg::OFS_GCTRL: begin
            regRead[tmr_pkg::GCTRL_SYNC_BIT] = syncMode;
            regRead[tmr_pkg::GCTRL_PSR_BIT] = prescReset;
         end
         tmr_pkg::OFS_TCTRL: begin
            regRead[tmr_pkg::TCTRL_CS_LSB +: 3] = clockSelect;
            regRead[tmr_pkg::TCTRL_WGM_LSB +: 3] = waveMode;
         end
         tmr_pkg::OFS_STATUS: regRead = counterValue;
         default: regRead = '0;
      endcase
   end

   // Read channel: one read outstanding
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= tmr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, regRead};
         s_axi_rresp <= isMapped(s_axi_araddr) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence pinRiseSeq;
      clockSelect == tmr_pkg::CS_EXT_RISE && !prescReset && !extCountPin
         ##1 extCountPin [*4];
   endsequence

   sequence flagWriteSeq(logic bitIn);
      wrHit(tmr_pkg::OFS_FLAGS) && bitIn;
   endsequence

   sequence matchASeq;
      countPulseD && counterValue == compareA;
   endsequence

   cmp_a_flag_a: assert property (matchASeq |=> eventPulse.cmpA ##1 flags.cmpA)
      else $error("compare A match did not set flag");

   cmp_b_flag_a: assert property (countPulseD && counterValue == compareB |=> ##1 flags.cmpB)
      else $error("compare B match did not set flag");

   irq_gate_a: assert property (irqReq != '0 |-> $past(globalIrqEn) && (irqReq & ~$past(irqEn)) == '0)
      else $error("interrupt request without enable");

   irq_raise_a: assert property (flags.ovf && irqEn.ovf && globalIrqEn |=> irqReq.ovf)
      else $error("overflow request missing");

   flag_w1c_a: assert property (flagWriteSeq(wDataQ[tmr_pkg::FLAG_CMPB_BIT])
      ##0 !eventPulse.cmpB |=> !flags.cmpB)
      else $error("write one did not clear compare B flag");

   set_wins_a: assert property (vectorAck.ovf && eventPulse.ovf |=> flags.ovf)
      else $error("flag set lost to clear");

   vec_clear_a: assert property (vectorAck.cmpA && !eventPulse.cmpA |=> !flags.cmpA)
      else $error("vector did not clear compare A flag");

   rsvd_read_a: assert property (s_axi_arvalid && s_axi_arready
      && (s_axi_araddr == tmr_pkg::OFS_MASK || s_axi_araddr == tmr_pkg::OFS_FLAGS)
      |=> s_axi_rdata[0] == 1'b0 && s_axi_rdata[7] == 1'b0)
      else $error("reserved bit read as one");

   psr_clear_a: assert property (prescReset && !syncMode && !wrHit(tmr_pkg::OFS_GCTRL)
      |=> !prescReset)
      else $error("prescaler reset bit not cleared");

   sync_hold_a: assert property (prescReset && syncMode && !wrHit(tmr_pkg::OFS_GCTRL)
      |=> prescReset && !countPulse)
      else $error("prescaler reset not held in sync mode");

   div8_gap_a: assert property (countPulse && clockSelect == tmr_pkg::CS_DIV8
      && $stable(clockSelect) && !prescReset |=> (!countPulse || clockSelect != tmr_pkg::CS_DIV8) [*7])
      else $error("divide by 8 pulses too close");

   // pin rise counted within bounded delay
   ext_rise_a: assert property (pinRiseSeq |-> ##[0:1] countPulse)
      else $error("pin rise not counted in time");

endmodule
`default_nettype wire

// ---- tmr_timer0_cmp_tb.sv ----
// Self-checking bench for the timer compare, flag and prescaler block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end
module tmr_timer0_cmp_tb;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_axi_awaddr = '0;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = '0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [7:0] counterValue = 8'hC0;
   logic globalIrqEn = 1'b0;
   tmr_pkg::tmr_evt_t vectorAck = '0;
   logic extCountPin = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, countPulse;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   tmr_pkg::tmr_evt_t eventPulse, irqReq;
   logic [2:0] clockSelect, waveMode;
   logic [31:0] expR[$];
   logic [1:0] expRr[$], expB[$];
   logic [31:0] er;
   logic [1:0] eb;
   logic [7:0] a, b;
   logic [7:0] cnt[4];
   logic [7:0] masks[3] = '{8'h04, 8'h08, 8'h02};
   logic [2:0] reqs[3] = '{3'b100, 3'b010, 3'b001};
   logic [2:0] evs[4] = '{3'b100, 3'b010, 3'b001, 3'b000};
   int span[6] = '{64, 64, 64, 512, 2048, 8192};
   int expP[6] = '{0, 64, 8, 8, 8, 8};
   int errors = 0;
   int num_checks = 0;
   int pulses = 0;
   int i, k, n0, lat, hp;
   int unsigned seed;

   tmr_timer0_cmp dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .counterValue(counterValue),
      .globalIrqEn(globalIrqEn), .vectorAck(vectorAck), .extCountPin(extCountPin),
      .countPulse(countPulse), .eventPulse(eventPulse), .irqReq(irqReq),
      .clockSelect(clockSelect), .waveMode(waveMode)
   );

   always #2 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      if (countPulse === 1'b1) begin
         pulses <= pulses + 1;
      end
   end

   // Monitor takes the oldest note whenever a response is handed over
   always @(posedge clk_sys) begin
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         eb = expB.pop_front();
         `CHK(s_axi_bresp, eb)
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         er = expR.pop_front();
         `CHK(s_axi_rdata, er)
         eb = expRr.pop_front();
         `CHK(s_axi_rresp, eb)
      end
   end

   task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] rs);
      expB.push_back(rs);
      s_axi_awaddr <= ad;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] rs);
      expR.push_back({24'h000000, d});
      expRr.push_back(rs);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic ack(input tmr_pkg::tmr_evt_t v);
      vectorAck <= v;
      @(posedge clk_sys);
      vectorAck <= '0;
   endtask

   task automatic results();
      $display("Checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      #200000;
      errors++;
      $display("ERROR %0t: watchdog expired", $time);
      results();
   end

   initial begin
      seed = $urandom(52354);
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      for (i = 0; i < 6; i++) rd(8'(4 * i), tmr_pkg::REG_RESET, tmr_pkg::RESP_OKAY);
      rd(tmr_pkg::OFS_STATUS, 8'hC0, tmr_pkg::RESP_OKAY);
      rd(8'h1C, 8'h00, tmr_pkg::RESP_SLVERR);
      wr(8'h1C, 8'hFF, tmr_pkg::RESP_SLVERR);
      a = 8'($urandom_range(63, 1));
      b = a + 8'h40;
      wr(tmr_pkg::OFS_CMP_A, a, tmr_pkg::RESP_OKAY);
      wr(tmr_pkg::OFS_CMP_B, b, tmr_pkg::RESP_OKAY);
      s_axi_wstrb <= 4'hE;
      wr(tmr_pkg::OFS_CMP_A, 8'hFF, tmr_pkg::RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(tmr_pkg::OFS_CMP_A, a, tmr_pkg::RESP_OKAY);
      rd(tmr_pkg::OFS_CMP_B, b, tmr_pkg::RESP_OKAY);
      wr(tmr_pkg::OFS_MASK, 8'hFF, tmr_pkg::RESP_OKAY);
      rd(tmr_pkg::OFS_MASK, 8'h0E, tmr_pkg::RESP_OKAY);
      wr(tmr_pkg::OFS_TCTRL, {2'b00, tmr_pkg::WGM_NORMAL, tmr_pkg::CS_SYS}, tmr_pkg::RESP_OKAY);
      // counter passes both compares and the top
      globalIrqEn <= 1'b1;
      cnt = '{a, b, tmr_pkg::CNT_MAX, 8'hC0};
      for (i = 0; i < 4; i++) begin
         counterValue <= cnt[i];
         repeat (2) @(posedge clk_sys);
         `CHK(eventPulse, evs[i])
      end
      repeat (4) @(posedge clk_sys);
      rd(tmr_pkg::OFS_FLAGS, 8'h1A, tmr_pkg::RESP_OKAY);
      `CHK(irqReq, 3'b111)
      globalIrqEn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK(irqReq, 3'b000)
      globalIrqEn <= 1'b1;
      for (i = 0; i < 3; i++) begin
         wr(tmr_pkg::OFS_MASK, masks[i], tmr_pkg::RESP_OKAY);
         repeat (3) @(posedge clk_sys);
         `CHK(irqReq, reqs[i])
      end
      wr(tmr_pkg::OFS_FLAGS, 8'h81, tmr_pkg::RESP_OKAY);
      rd(tmr_pkg::OFS_FLAGS, 8'h1A, tmr_pkg::RESP_OKAY);
      wr(tmr_pkg::OFS_FLAGS, 8'h08, tmr_pkg::RESP_OKAY);
      rd(tmr_pkg::OFS_FLAGS, 8'h12, tmr_pkg::RESP_OKAY);
      ack(3'b100);
      rd(tmr_pkg::OFS_FLAGS, 8'h02, tmr_pkg::RESP_OKAY);
      ack(3'b001);
      rd(tmr_pkg::OFS_FLAGS, 8'h00, tmr_pkg::RESP_OKAY);
      // Overflow event and vector clear in one cycle
      counterValue <= tmr_pkg::CNT_MAX;
      repeat (2) @(posedge clk_sys);
      counterValue <= 8'hC0;
      ack(3'b001);
      rd(tmr_pkg::OFS_FLAGS, 8'h02, tmr_pkg::RESP_OKAY);
      // Overflow at compare A top, then at bottom
      wr(tmr_pkg::OFS_TCTRL, {2'b00, tmr_pkg::WGM_FAST_TOPA, tmr_pkg::CS_SYS},
         tmr_pkg::RESP_OKAY);
      counterValue <= a;
      repeat (2) @(posedge clk_sys);
      `CHK(eventPulse, 3'b101)
      wr(tmr_pkg::OFS_TCTRL, {2'b00, tmr_pkg::WGM_PC_MAX, tmr_pkg::CS_SYS},
         tmr_pkg::RESP_OKAY);
      counterValue <= tmr_pkg::CNT_BOTTOM;
      repeat (2) @(posedge clk_sys);
      `CHK(eventPulse, 3'b001)
      counterValue <= 8'hC0;
      // every internal source over whole prescaler periods
      for (k = 0; k < 6; k++) begin
         wr(tmr_pkg::OFS_TCTRL, {2'b00, 3'(k), 3'(k)}, tmr_pkg::RESP_OKAY);
         `CHK(clockSelect, 3'(k))
         `CHK(waveMode, 3'(k))
         repeat (4) @(posedge clk_sys);
         n0 = pulses;
         repeat (span[k]) @(posedge clk_sys);
         `CHK(pulses - n0, expP[k])
      end
      wr(tmr_pkg::OFS_TCTRL, {5'h00, tmr_pkg::CS_DIV8}, tmr_pkg::RESP_OKAY);
      wr(tmr_pkg::OFS_GCTRL, 8'h01, tmr_pkg::RESP_OKAY);
      rd(tmr_pkg::OFS_GCTRL, 8'h00, tmr_pkg::RESP_OKAY);
      wr(tmr_pkg::OFS_GCTRL, 8'h81, tmr_pkg::RESP_OKAY);
      rd(tmr_pkg::OFS_GCTRL, 8'h81, tmr_pkg::RESP_OKAY);
      n0 = pulses;
      repeat (32) @(posedge clk_sys);
      `CHK(pulses - n0, 0)
      wr(tmr_pkg::OFS_GCTRL, 8'h00, tmr_pkg::RESP_OKAY);
      n0 = pulses;
      repeat (12) @(posedge clk_sys);
      `CHK(pulses - n0, 1)
      rd(tmr_pkg::OFS_GCTRL, 8'h00, tmr_pkg::RESP_OKAY);
      // Pin held low and stable before the source is switched
      wr(tmr_pkg::OFS_TCTRL, {5'h00, tmr_pkg::CS_EXT_RISE}, tmr_pkg::RESP_OKAY);
      extCountPin <= 1'b1;
      lat = 0;
      do begin
         @(posedge clk_sys);
         lat++;
      end while (countPulse !== 1'b1 && lat < 10);
      `CHK(lat inside {[3:4]}, 1'b1)
      extCountPin <= 1'b0;
      repeat (6) @(posedge clk_sys);
      for (k = 0; k < 2; k++) begin
         wr(tmr_pkg::OFS_TCTRL, {5'h00, k ? tmr_pkg::CS_EXT_FALL : tmr_pkg::CS_EXT_RISE},
            tmr_pkg::RESP_OKAY);
         n0 = pulses;
         // half periods of two to four clocks
         for (i = 0; i < 8; i++) begin
            hp = $urandom_range(4, 2);
            extCountPin <= 1'b1;
            repeat (hp) @(posedge clk_sys);
            extCountPin <= 1'b0;
            repeat (hp) @(posedge clk_sys);
         end
         repeat (6) @(posedge clk_sys);
         `CHK(pulses - n0, 8)
      end
      results();
   end
endmodule
`undef CHK
`default_nettype wire
